// ---- include/limit_output_defs.vh ----
/*
 * Constants of the limit switch output block: register map, configuration
 * field positions, watch data types, axis data items and timing figures.
 * Assumes inclusion by bare name from design and bench files alike.
 */
`ifndef LIMIT_OUTPUT_DEFS_VH
`define LIMIT_OUTPUT_DEFS_VH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 100
`define OP_CYCLE_NS 1000000
`define OP_CYCLE_CLKS (`OP_CYCLE_NS / `CLK_PERIOD_NS)

// ----------------------------------------------------------------------
// Register map (word addresses)
// ----------------------------------------------------------------------
`define ADDR_W 10
`define PT_REG_CFG 3'h0
`define PT_REG_WATCH 3'h1
`define PT_REG_ON_LO 3'h2
`define PT_REG_ON_HI 3'h3
`define PT_REG_OFF_LO 3'h4
`define PT_REG_OFF_HI 3'h5
`define REGION_POINTS 2'h0
`define REGION_WORDS 2'h2
`define ADDR_STATUS 10'h300
`define ADDR_OUT_BITS 10'h301
`define CFG_RESET 32'h00000000

// ----------------------------------------------------------------------
// Point configuration word fields
// ----------------------------------------------------------------------
`define CFG_TGT 4:0
`define CFG_TYPE 6:5
`define CFG_SRC_AXIS 7
`define CFG_AX_NUM 12:8
`define CFG_AX_ITEM 15:13
`define CFG_ON_CONST 16
`define CFG_OFF_CONST 17
`define CFG_EN_SEL 23:18
`define CFG_EN_USE 24
`define CFG_FRC_SEL 30:25
`define CFG_FRC_USE 31

// ----------------------------------------------------------------------
// Watch data types and axis data items
// ----------------------------------------------------------------------
`define TYPE_I16 2'h0
`define TYPE_I32 2'h1
`define TYPE_F64 2'h2
`define ITEM_FEED 3'h0
`define ITEM_REAL 3'h1
`define ITEM_DEVIATION 3'h2
`define ITEM_CURRENT 3'h3
`define ITEM_SPEED 3'h4
`define ITEM_CAM 3'h5
`define ITEM_VFEED 3'h6
`define ITEM_ENCODER 3'h7

`endif

// ---- rtl/limit_output_compare.v ----
/*
 * Limit switch output block: up to 32 points, each comparing a watch value
 * with an ON and an OFF value and driving one bit of an output image.
 * Assumes a same-clock register port, a same-clock axis data source that
 * answers one cycle after the select, and same-clock flag and ready inputs.
 */
`timescale 1ns/100ps
`include "limit_output_defs.vh"

// Behaviour
// - Up to 32 independently configured limit output points.
// - Each point holds target bit, watch source, ON, OFF, enable and force.
// - Watch from axis data or a word as 16-bit, 32-bit or 64-bit float.
// - ON and OFF values use the same type as the watch value.
// - ON and OFF come from a word location or a fixed constant.
// - No enable bit: always enabled; enable low forces output low.
// - Enable and force bits selectable from the bit image or unused.
// - Output bit set or cleared by the ON region comparison.
// - Axis positions and error are 32-bit; current and speed 16-bit.
// - Virtual axis and encoder sources are 32-bit, ranges 10 and 12.
// - Signed compare; wrap region when ON above OFF; off when equal.
// - Force bit high drives output high, overriding disable.
// - Points sharing a target bit are ORed together.
module limit_output_compare #(
	parameter POINTS = 32,
	parameter OUT_BITS = 32,
	parameter FLAG_BITS = 64,
	parameter WORDS = 256,
	parameter AXES = 32,
	parameter VIRTUAL_AXES = 10,
	parameter ENCODERS = 12,
	parameter OP_CYCLE_CLKS = `OP_CYCLE_CLKS
) (
	input wire clk_sys_in,
	input wire rst_b_in,
	input wire [`ADDR_W-1:0] reg_addr_in,
	input wire [31:0] reg_wdata_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	output wire [31:0] reg_rdata_out,
	input wire controller_ready_flag_in,
	output wire processor_ready_flag_out,
	input wire [FLAG_BITS-1:0] flag_bits_in,
	output wire [4:0] axis_num_out,
	output wire [2:0] axis_item_out,
	input wire [31:0] axis_value_in,
	output wire [OUT_BITS-1:0] out_bits_out
);

	// ------------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------------
	localparam S_IDLE = 2'd0;
	localparam S_FETCH = 2'd1;
	localparam S_EVAL = 2'd2;

	reg [31:0] cfg_r [0:POINTS-1];
	reg [31:0] watch_r [0:POINTS-1];
	reg [31:0] on_lo_r [0:POINTS-1];
	reg [31:0] on_hi_r [0:POINTS-1];
	reg [31:0] off_lo_r [0:POINTS-1];
	reg [31:0] off_hi_r [0:POINTS-1];
	reg [15:0] word_mem [0:WORDS-1];

	reg [31:0] rdata_r;
	reg [1:0] state_r;
	reg [4:0] pt_r;
	reg [OUT_BITS-1:0] acc_r;
	reg [OUT_BITS-1:0] out_bits_r;
	reg ready_r;
	reg [31:0] tick_cnt_r;
	reg tick_r;
	reg [4:0] axis_num_r;
	reg [2:0] axis_item_r;
	integer i;

	wire [1:0] region = reg_addr_in[9:8];
	wire [4:0] wr_pt = reg_addr_in[7:3];
	wire [2:0] wr_reg = reg_addr_in[2:0];
	wire pt_hit = (region == `REGION_POINTS) && ({27'h0, wr_pt} < POINTS);
	// Ready is a same-clock level, so one cycle of history is enough for its edge.
	wire ready_rise = controller_ready_flag_in & ~ready_r;

	assign reg_rdata_out = rdata_r;
	assign processor_ready_flag_out = ready_r;
	assign out_bits_out = out_bits_r;
	assign axis_num_out = axis_num_r;
	assign axis_item_out = axis_item_r;

	// ------------------------------------------------------------------
	// Value helpers
	// ------------------------------------------------------------------
	// Words are read with the low word at the given index. A wide value
	// at an odd index would straddle two values, so the low bit is dropped.
	function [63:0] word_value;
		input [7:0] idx;
		input [1:0] typ;
		reg [7:0] base;
		begin
			base = (typ == `TYPE_I16) ? idx : {idx[7:1], 1'b0};
			case (typ)
				`TYPE_I16: word_value = {{48{word_mem[base][15]}}, word_mem[base]};
				`TYPE_I32: word_value = {{32{word_mem[base + 8'h01][15]}},
					word_mem[base + 8'h01], word_mem[base]};
				default: word_value = {word_mem[base + 8'h03], word_mem[base + 8'h02],
					word_mem[base + 8'h01], word_mem[base]};
			endcase
		end
	endfunction

	// Maps any watch type onto one unsigned order so a single comparator
	// serves integers and doubles alike.
	function [63:0] order_key;
		input [63:0] v;
		input [1:0] typ;
		reg [63:0] ext;
		begin
			case (typ)
				`TYPE_I16: ext = {{48{v[15]}}, v[15:0]};
				`TYPE_I32: ext = {{32{v[31]}}, v[31:0]};
				default: ext = v;
			endcase
			if (typ == `TYPE_F64 && ext[63]) begin
				order_key = ~ext;
			end else begin
				order_key = {~ext[63], ext[62:0]};
			end
		end
	endfunction

	// ------------------------------------------------------------------
	// Point evaluation
	// ------------------------------------------------------------------
	reg [31:0] cfg;
	reg [1:0] typ;
	reg axis_ok;
	reg [63:0] watch_v;
	reg [63:0] on_v;
	reg [63:0] off_v;
	reg [63:0] watch_k;
	reg [63:0] on_k;
	reg [63:0] off_k;
	reg in_region;
	reg enabled;
	reg forced;
	reg result;
	reg [OUT_BITS-1:0] acc_nxt;

	// Word memory is read inside functions, so a write alone does not wake this
	// block; the next point step re-reads it, and a scan in flight may see the old word.
	always @* begin
		cfg = cfg_r[pt_r];
		axis_ok = 1'b1;
		if (cfg[`CFG_SRC_AXIS]) begin
			case (axis_item_r)
				`ITEM_CURRENT, `ITEM_SPEED: begin
					typ = `TYPE_I16;
					axis_ok = ({27'h0, axis_num_r} < AXES);
				end
				`ITEM_FEED, `ITEM_REAL, `ITEM_DEVIATION: begin
					typ = `TYPE_I32;
					axis_ok = ({27'h0, axis_num_r} < AXES);
				end
				`ITEM_ENCODER: begin
					typ = `TYPE_I32;
					axis_ok = ({27'h0, axis_num_r} < ENCODERS);
				end
				default: begin
					typ = `TYPE_I32;
					axis_ok = ({27'h0, axis_num_r} < VIRTUAL_AXES);
				end
			endcase
			watch_v = {32'h0, axis_value_in};
		end else begin
			typ = (cfg[`CFG_TYPE] == `TYPE_F64) ? `TYPE_F64 : cfg[`CFG_TYPE] & 2'h1;
			watch_v = word_value(watch_r[pt_r][7:0], typ);
		end
		if (cfg[`CFG_ON_CONST]) begin
			on_v = {on_hi_r[pt_r], on_lo_r[pt_r]};
		end else begin
			on_v = word_value(on_lo_r[pt_r][7:0], typ);
		end
		if (cfg[`CFG_OFF_CONST]) begin
			off_v = {off_hi_r[pt_r], off_lo_r[pt_r]};
		end else begin
			off_v = word_value(off_lo_r[pt_r][7:0], typ);
		end
		watch_k = order_key(watch_v, typ);
		on_k = order_key(on_v, typ);
		off_k = order_key(off_v, typ);
		if (on_k < off_k) begin
			in_region = (watch_k >= on_k) && (watch_k < off_k);
		end else if (on_k > off_k) begin
			in_region = (watch_k >= on_k) || (watch_k < off_k);
		end else begin
			in_region = 1'b0;
		end
		enabled = ~cfg[`CFG_EN_USE] | flag_bits_in[cfg[`CFG_EN_SEL]];
		forced = cfg[`CFG_FRC_USE] & flag_bits_in[cfg[`CFG_FRC_SEL]];
		// Force wins over a low enable bit and over an axis number out of range.
		result = forced | (enabled & axis_ok & in_region);
		acc_nxt = acc_r | ({{(OUT_BITS-1){1'b0}}, result} << cfg[`CFG_TGT]);
	end

	// ------------------------------------------------------------------
	// Operation cycle divider
	// ------------------------------------------------------------------
	// Ticks that land during a scan are dropped, so OP_CYCLE_CLKS must exceed
	// a full scan of two cycles a point, or every other tick is lost.
	always @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			tick_cnt_r <= 32'h0;
			tick_r <= 1'b0;
		end else if (tick_cnt_r == OP_CYCLE_CLKS - 1) begin
			tick_cnt_r <= 32'h0;
			tick_r <= 1'b1;
		end else begin
			tick_cnt_r <= tick_cnt_r + 32'h1;
			tick_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Scan sequencer
	// ------------------------------------------------------------------
	// A rising ready starts a scan at once, so word-held ON and OFF values
	// are taken without waiting for the next tick.
	always @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_r <= S_IDLE;
			pt_r <= 5'h0;
			acc_r <= {OUT_BITS{1'b0}};
			out_bits_r <= {OUT_BITS{1'b0}};
			ready_r <= 1'b0;
			axis_num_r <= 5'h0;
			axis_item_r <= 3'h0;
		end else begin
			ready_r <= controller_ready_flag_in;
			if (!controller_ready_flag_in) begin
				state_r <= S_IDLE;
				out_bits_r <= {OUT_BITS{1'b0}};
			end else begin
				case (state_r)
					S_IDLE: begin
						if (tick_r || ready_rise) begin
							pt_r <= 5'h0;
							acc_r <= {OUT_BITS{1'b0}};
							state_r <= S_FETCH;
						end
					end
					S_FETCH: begin
						// The select is registered here, so the far side has the whole
						// EVAL cycle to answer before the result is taken.
						axis_num_r <= cfg_r[pt_r][`CFG_AX_NUM];
						axis_item_r <= cfg_r[pt_r][`CFG_AX_ITEM];
						state_r <= S_EVAL;
					end
					S_EVAL: begin
						acc_r <= acc_nxt;
						if ({27'h0, pt_r} == POINTS - 1) begin
							out_bits_r <= acc_nxt;
							state_r <= S_IDLE;
						end else begin
							pt_r <= pt_r + 5'h1;
							state_r <= S_FETCH;
						end
					end
					default: begin
						state_r <= S_IDLE;
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// Register port
	// ------------------------------------------------------------------
	// Target bits are not checked against reserved or read-only spaces;
	// software owns that choice and a bad target simply drives that bit.
	always @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			for (i = 0; i < POINTS; i = i + 1) begin
				cfg_r[i] <= `CFG_RESET;
				watch_r[i] <= 32'h0;
				on_lo_r[i] <= 32'h0;
				on_hi_r[i] <= 32'h0;
				off_lo_r[i] <= 32'h0;
				off_hi_r[i] <= 32'h0;
			end
		end else if (reg_wr_in && pt_hit) begin
			case (wr_reg)
				`PT_REG_CFG: cfg_r[wr_pt] <= reg_wdata_in;
				`PT_REG_WATCH: watch_r[wr_pt] <= reg_wdata_in;
				`PT_REG_ON_LO: on_lo_r[wr_pt] <= reg_wdata_in;
				`PT_REG_ON_HI: on_hi_r[wr_pt] <= reg_wdata_in;
				`PT_REG_OFF_LO: off_lo_r[wr_pt] <= reg_wdata_in;
				`PT_REG_OFF_HI: off_hi_r[wr_pt] <= reg_wdata_in;
				default: begin
				end
			endcase
		end
	end

	// Word memory holds data, not control, so it carries no reset.
	always @(posedge clk_sys_in) begin
		if (reg_wr_in && region == `REGION_WORDS && {24'h0, reg_addr_in[7:0]} < WORDS) begin
			word_mem[reg_addr_in[7:0]] <= reg_wdata_in[15:0];
		end
	end

	// Read data stand for one cycle and fall back to zero, so a bus that ORs
	// several slaves together never sees a stale answer.

	always @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rdata_r <= 32'h0;
		end else if (reg_rd_in) begin
			rdata_r <= 32'h0;
			if (pt_hit) begin
				case (wr_reg)
					`PT_REG_CFG: rdata_r <= cfg_r[wr_pt];
					`PT_REG_WATCH: rdata_r <= watch_r[wr_pt];
					`PT_REG_ON_LO: rdata_r <= on_lo_r[wr_pt];
					`PT_REG_ON_HI: rdata_r <= on_hi_r[wr_pt];
					`PT_REG_OFF_LO: rdata_r <= off_lo_r[wr_pt];
					`PT_REG_OFF_HI: rdata_r <= off_hi_r[wr_pt];
					default: rdata_r <= 32'h0;
				endcase
			end else if (region == `REGION_WORDS && {24'h0, reg_addr_in[7:0]} < WORDS) begin
				rdata_r <= {16'h0, word_mem[reg_addr_in[7:0]]};
			end else if (reg_addr_in == `ADDR_STATUS) begin
				rdata_r <= {29'h0, state_r, ready_r};
			end else if (reg_addr_in == `ADDR_OUT_BITS) begin
				rdata_r <= out_bits_r;
			end
		end else begin
			rdata_r <= 32'h0;
		end
	end

endmodule // limit_output_compare

// ---- testbench/limit_output_props.sv ----
/*
 * Checker of the limit switch output block, bound to its top module.
 * Assumes the block's register port, ready handshake and output image.
 */
`timescale 1ns/100ps
`include "limit_output_defs.vh"
module limit_output_props #(
	parameter OUT_BITS = 32
) (
	input wire clk_sys_in,
	input wire rst_b_in,
	input wire [`ADDR_W-1:0] reg_addr_in,
	input wire reg_rd_in,
	input wire [31:0] reg_rdata_out,
	input wire controller_ready_flag_in,
	input wire processor_ready_flag_out,
	input wire [OUT_BITS-1:0] out_bits_out
);
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!rst_b_in);
	// ----
	// Sequences
	// ----
	sequence rd_at(a);
		reg_rd_in && reg_addr_in == a;
	endsequence
	// A scan result that changes while ready is high must stand for the next cycle.
	sequence out_step;
		$changed(out_bits_out) ##1 $past(controller_ready_flag_in);
	endsequence
	// ----
	// Properties
	// ----
	rdata_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
		else $error("read data not zero outside read");
	gap_read_a: assert property (
		reg_rd_in && reg_addr_in < 10'h100 && reg_addr_in[2:1] == 2'h3
		|=> reg_rdata_out == 32'h0)
		else $error("unused point slot read nonzero");
	out_read_a: assert property (rd_at(`ADDR_OUT_BITS)
		|=> reg_rdata_out == $past(out_bits_out))
		else $error("output image read mismatch");
	rdy_read_a: assert property (rd_at(`ADDR_STATUS)
		|=> reg_rdata_out[0] == $past(processor_ready_flag_out))
		else $error("status ready bit mismatch");
	rdy_rise_a: assert property ($rose(controller_ready_flag_in)
		|=> processor_ready_flag_out)
		else $error("processor ready late");
	clear_low_a: assert property (!controller_ready_flag_in
		|=> out_bits_out == '0 && !processor_ready_flag_out)
		else $error("outputs not cleared on ready low");
	out_ready_a: assert property (out_bits_out != '0 |-> processor_ready_flag_out)
		else $error("output set while not ready");
	out_hold_a: assert property (out_step |-> $stable(out_bits_out))
		else $error("output image changed twice in a scan");
endmodule // limit_output_props

bind limit_output_compare limit_output_props #(.OUT_BITS(OUT_BITS)) chk (
	.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in),
	.reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
	.controller_ready_flag_in(controller_ready_flag_in),
	.processor_ready_flag_out(processor_ready_flag_out), .out_bits_out(out_bits_out));

// ---- testbench/axis_data_model.sv ----
/*
 * Axis data source: answers an axis select at the next falling edge, so the
 * value stands at the rising edge that ends the cycle after the select.
 * Assumes the block's clock and reset.
 */
`timescale 1ns/100ps
module axis_data_model (
	input wire clk_sys_in,
	input wire rst_b_in,
	input wire [4:0] axis_num_in,
	input wire [2:0] axis_item_in,
	output reg [31:0] axis_value_out
);
	// The upper byte makes a 16-bit item read as 32 bits land outside its region.
	always @(negedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in)
			axis_value_out <= 32'h0;
		else
			axis_value_out <= {8'h01, 16'h0, axis_item_in, axis_num_in};
	end
endmodule // axis_data_model

// ---- testbench/limit_output_compare_tb.sv ----
/*
 * Bench of the limit switch output block: register tasks, a point table
 * and checks of the output image.
 * Assumes the axis data model on the far side of the axis port.
 */
`timescale 1ns/100ps
`include "limit_output_defs.vh"
module limit_output_compare_tb;
	reg clk_sys_in = 1'b0;
	reg rst_b_in = 1'b0;
	reg reg_wr_in = 1'b0;
	reg reg_rd_in = 1'b0;
	reg controller_ready_flag_in = 1'b0;
	reg [`ADDR_W-1:0] reg_addr_in = 10'h000;
	reg [31:0] reg_wdata_in = 32'h0;
	reg [63:0] flag_bits_in = 64'h0;
	wire [31:0] reg_rdata_out;
	wire [31:0] axis_value_in;
	wire [31:0] out_bits_out;
	wire processor_ready_flag_out;
	wire [4:0] axis_num_out;
	wire [2:0] axis_item_out;
	integer fail_count = 0;
	integer n_tests = 0;
	reg [6:0] p;
	reg [7:0] k;
	// ----
	// Point table: configuration, ON and OFF values, watch words
	// ----
	// Targets stay in plain writable bits.
	logic [31:0] tc [0:13] = '{32'h00030020, 32'h00030021, 32'h00030022,
		32'h00030023, 32'h00030024, 32'h80030025, 32'h01070026, 32'h00030021,
		32'h00030021, 32'h00030289, 32'h0003628a, 32'h0003ec8b, 32'h0, 32'h0002002d};
	logic [31:0] ton [0:13] = '{32'h0, 32'h6, 32'ha, 32'h5, 32'hfffffffb, 32'h6,
		32'h0, 32'h0, 32'h6, 32'h01000000, 32'h60, 32'h0, 32'h0, 32'h6};
	logic [31:0] toff [0:13] = '{32'ha, 32'ha, 32'h6, 32'h5, 32'h0, 32'ha, 32'ha,
		32'ha, 32'ha, 32'h01000003, 32'h70, 32'h7fffffff, 32'h0, 32'ha};
	logic [15:0] tw [0:11] = '{16'h5, 16'h0, 16'hfffd, 16'hffff, 16'h0, 16'h0, 16'h0, 16'h0,
		16'h0, 16'h0, 16'h0, 16'hbff8};

	limit_output_compare #(.OP_CYCLE_CLKS(100)) uut (.clk_sys_in(clk_sys_in),
		.rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
		.reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
		.controller_ready_flag_in(controller_ready_flag_in),
		.processor_ready_flag_out(processor_ready_flag_out),
		.flag_bits_in(flag_bits_in), .axis_num_out(axis_num_out),
		.axis_item_out(axis_item_out), .axis_value_in(axis_value_in),
		.out_bits_out(out_bits_out));
	axis_data_model axis_src (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
		.axis_num_in(axis_num_out), .axis_item_in(axis_item_out),
		.axis_value_out(axis_value_in));

	initial forever #50 clk_sys_in = ~clk_sys_in;
	// ----
	// Tasks
	// ----
	task give_verdict;
		begin
			$display("checks %0d, mismatches %0d", n_tests, fail_count);
			if (fail_count == 0 && n_tests > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	task ck(input [31:0] g, input [31:0] e);
		begin
			n_tests = n_tests + 1;
			if (g !== e) begin
				fail_count = fail_count + 1;
				$display("CHECK FAILED at %0t: got %h, want %h", $time, g, e);
			end
		end
	endtask
	task wr(input [`ADDR_W-1:0] a, input [31:0] d);
		begin
			@(posedge clk_sys_in);
			reg_wr_in <= 1'b1;
			reg_addr_in <= a;
			reg_wdata_in <= d;
			@(posedge clk_sys_in);
			reg_wr_in <= 1'b0;
		end
	endtask
	task rd(input [`ADDR_W-1:0] a, input [31:0] e);
		begin
			@(posedge clk_sys_in);
			reg_rd_in <= 1'b1;
			reg_addr_in <= a;
			@(posedge clk_sys_in);
			reg_rd_in <= 1'b0;
			#1 ck(reg_rdata_out, e);
		end
	endtask
	task pt(input [6:0] n, input [31:0] c, input [31:0] w, input [31:0] on, input [31:0] off);
		begin
			wr({n, `PT_REG_CFG}, c);
			wr({n, `PT_REG_WATCH}, w);
			wr({n, `PT_REG_ON_LO}, on);
			wr({n, `PT_REG_OFF_LO}, off);
		end
	endtask
	// One tick period plus a full scan is always enough for a fresh image.
	task settle;
		begin
			repeat (170) @(posedge clk_sys_in);
			#1;
		end
	endtask
	// ----
	// Sequence
	// ----
	initial begin
		repeat (5) @(posedge clk_sys_in);
		rst_b_in <= 1'b1;
		#1 ck(out_bits_out, 32'h0);
		rd({7'h14, `PT_REG_CFG}, `CFG_RESET);
		for (k = 8'h00; k < 8'h0c; k = k + 8'h01)
			wr({`REGION_WORDS, k}, {16'h0, tw[k]});
		for (p = 7'h00; p < 7'h0e; p = p + 7'h01)
			pt(p, tc[p], {30'h0, p == 7'h04, 1'b0}, ton[p], toff[p]);
		pt(7'h1f, 32'h0003002e, 32'h0, 32'h0, 32'ha);
		wr({7'h0e, `PT_REG_ON_HI}, 32'hc0000000);
		wr({7'h0e, `PT_REG_OFF_HI}, 32'h3ff00000);
		pt(7'h0e, 32'h0003004f, 32'h8, 32'h0, 32'h0);
		pt(7'h0f, 32'h0003c990, 32'h0, 32'h010000c9, 32'h010000ca);
		pt(7'h10, 32'h0003aa91, 32'h0, 32'h01000000, 32'h7fffffff);
		pt(7'h11, 32'h00039f92, 32'h0, 32'h9f, 32'ha0);
		rd({7'h00, `PT_REG_CFG}, 32'h00030020);
		rd({7'h00, 3'h6}, 32'h0);
		@(posedge clk_sys_in);
		flag_bits_in <= 64'h3;
		controller_ready_flag_in <= 1'b1;
		settle;
		ck(out_bits_out, 32'h0005e677);
		rd(`ADDR_OUT_BITS, 32'h0005e677);
		@(posedge clk_sys_in);
		flag_bits_in <= 64'h0;
		settle;
		ck(out_bits_out, 32'h0005e617);
		wr({`REGION_WORDS, 8'h06}, 32'h6);
		settle;
		ck(out_bits_out, 32'h0005c617);
		@(posedge clk_sys_in);
		controller_ready_flag_in <= 1'b0;
		@(posedge clk_sys_in);
		#1 ck(out_bits_out, 32'h0);
		ck({31'h0, processor_ready_flag_out}, 32'h0);
		rd(`ADDR_STATUS, 32'h0);
		give_verdict;
	end
endmodule // limit_output_compare_tb
